/* rtl/link_sampler.sv */
`timescale 1ns/1ps
module link_sampler #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              rise0
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic         prev;
    logic         rise;
  } smp_s;

  smp_s smp_q;
  smp_s smp_d;

  // two stages, edge found on the second stage only
  always_comb begin
    smp_d      = smp_q;
    smp_d.s1   = din;
    smp_d.s2   = smp_q.s1;
    smp_d.prev = smp_q.s2[0];
    smp_d.rise = smp_q.s2[0] & ~smp_q.prev;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_q <= '0;
    end else begin
      smp_q <= smp_d;
    end
  end

  assign dout  = smp_q.s2;
  assign rise0 = smp_q.rise;
endmodule // link_sampler

/* rtl/rmii_cfg_pkg.sv */
package rmii_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] CTRL_STATUS_OFF = 8'h17;
  localparam logic [7:0] IRQ_STATUS_OFF  = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFF    = 8'h21;

  localparam int TX_SHIFT_BIT  = 8;
  localparam int REF_SEL_BIT   = 7;
  localparam int FIFO_NORM_BIT = 6;
  localparam int RMII_MODE_BIT = 5;
  localparam int REV_SEL_BIT   = 4;
  localparam int OVF_BIT       = 3;
  localparam int UNF_BIT       = 2;
  localparam int EBUF_LSB      = 0;
  localparam int EBUF_MSB      = 1;

  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_UNF_BIT = 1;

  localparam logic       TX_SHIFT_RST  = 1'b0;
  localparam logic       FIFO_NORM_RST = 1'b1;
  localparam logic       RMII_MODE_RST = 1'b0;
  localparam logic       REV_SEL_RST   = 1'b0;
  localparam logic [1:0] EBUF_RST      = 2'h1;
  localparam logic [1:0] IRQ_MASK_RST  = 2'h0;

  localparam int TOL_BITS_00 = 14;
  localparam int TOL_BITS_01 = 2;
  localparam int TOL_BITS_10 = 6;
  localparam int TOL_BITS_11 = 10;

  localparam int SYS_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int DIBIT_DIV      = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam int STRAP_SETTLE   = 3;

  typedef enum logic [1:0] {EB_IDLE, EB_FILL, EB_RUN, EB_TAIL} eb_state_e;
endpackage

/* rtl/rmii_config_status_bank.sv */
// Contract
// - bit 8 set shifts transmit clock
// - clock select loads from strap; 1=50MHz
// - bypass bit zero routes data around buffer
// - bypassed: drive recovered clock on rx clock
// - bit 5: one RMII, zero MII
// - revision 1.0: carrier valid held till end
// - revision 1.2: carrier valid toggles at end
// - overflow flag bit 3, cleared by read
// - underflow flag bit 2, cleared by read
// - size field maps tolerance 14/2/6/10 bits
// - buffer absorbs rate difference of link
// - RGMII enable overrides RMII mode bit
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module rmii_config_status_bank
  import rmii_cfg_pkg::*;
#(
  parameter int EB_DEPTH = 16,
  parameter int RD_DIV   = DIBIT_DIV
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [DATA_W-1:0] RDATA,
  output logic                   IRQ,
  input  wire logic              RX_LINK_CLK,
  input  wire logic              RX_DV_IN,
  input  wire logic [1:0]        RXD_IN,
  input  wire logic              REF_CLOCK_FREQ_STRAP,
  input  wire logic              RGMII_EN,
  output logic                   CRS_DV,
  output logic      [1:0]        RXD,
  output logic                   RX_CLK_OUT,
  output logic                   TX_CLK_SHIFT_EN,
  output logic                   REF_CLK_50M_SEL,
  output logic                   RMII_MODE_ACT,
  output logic                   RX_FIFO_BYPASSED
);
  localparam int FW = $clog2(EB_DEPTH) + 1;

  typedef struct packed {
    eb_state_e   state;
    logic        tx_shift;
    logic        ref_sel;
    logic        fifo_norm;
    logic        rmii_mode;
    logic        rev10;
    logic        ovf;
    logic        unf;
    logic [1:0]  ebuf_size;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [15:0] rdata;
    logic        irq;
    logic [1:0]  strap_cnt;
    logic [7:0]  div_cnt;
    logic        tog;
    logic        crs_dv;
    logic [1:0]  rxd;
    logic        rx_clk_out;
    logic        tx_shift_o;
    logic        ref_sel_o;
    logic        rmii_act_o;
    logic        bypass_o;
  } bank_s;

  bank_s bank_q;
  bank_s bank_d;

  logic [5:0]    smp;
  logic          link_rise;
  logic          eb_clr;
  logic          eb_wr;
  logic          eb_rd;
  logic [1:0]    eb_rdata;
  logic [FW-1:0] eb_fill;

  // tolerance in dibits for a size code
  function automatic logic [FW-1:0] tol_dibits(input logic [1:0] sz);
    logic [FW-1:0] t;
    t = '0;
    case (sz)
      2'h0:    t = FW'(TOL_BITS_00 / 2);
      2'h1:    t = FW'(TOL_BITS_01 / 2);
      2'h2:    t = FW'(TOL_BITS_10 / 2);
      default: t = FW'(TOL_BITS_11 / 2);
    endcase
    return t;
  endfunction

  // which register an address selects, one hot
  function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] a);
    logic [2:0] h;
    h = 3'h0;
    if (a == CTRL_STATUS_OFF) begin
      h = 3'h1;
    end else if (a == IRQ_STATUS_OFF) begin
      h = 3'h2;
    end else if (a == IRQ_MASK_OFF) begin
      h = 3'h4;
    end
    return h;
  endfunction

  link_sampler #(
    .W (6)
  ) u_sampler (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   ({RGMII_EN, REF_CLOCK_FREQ_STRAP, RXD_IN, RX_DV_IN, RX_LINK_CLK}),
    .dout  (smp),
    .rise0 (link_rise)
  );

  rx_elastic_buffer #(
    .DEPTH (EB_DEPTH),
    .W     (2)
  ) u_ebuf (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .clr   (eb_clr),
    .wr    (eb_wr),
    .wdata (smp[3:2]),
    .rd    (eb_rd),
    .rdata (eb_rdata),
    .fill  (eb_fill)
  );

  always_comb begin
    logic          lclk_s;
    logic          dv_s;
    logic [1:0]    rxd_s;
    logic          strap_s;
    logic          rgmii_s;
    logic          rmii_act;
    logic          bypass;
    logic          tick;
    logic          ovf_ev;
    logic          unf_ev;
    logic [FW-1:0] tol;
    logic [FW-1:0] lim;
    logic [15:0]   rv;
    logic [2:0]    hit;
    lclk_s   = smp[0];
    dv_s     = smp[1];
    rxd_s    = smp[3:2];
    strap_s  = smp[4];
    rgmii_s  = smp[5];
    hit      = reg_hit(ADDR);
    rmii_act = ~rgmii_s & bank_q.rmii_mode;
    bypass   = rmii_act & ~bank_q.fifo_norm;
    tick     = (bank_q.div_cnt == 8'(RD_DIV - 1));
    ovf_ev   = 1'b0;
    unf_ev   = 1'b0;
    tol      = tol_dibits(bank_q.ebuf_size);
    lim      = {tol[FW-2:0], 1'b0};
    eb_clr   = 1'b0;
    eb_wr    = 1'b0;
    eb_rd    = 1'b0;
    bank_d   = bank_q;

    rv                     = '0;
    rv[TX_SHIFT_BIT]       = bank_q.tx_shift;
    rv[REF_SEL_BIT]        = bank_q.ref_sel;
    rv[FIFO_NORM_BIT]      = bank_q.fifo_norm;
    rv[RMII_MODE_BIT]      = bank_q.rmii_mode;
    rv[REV_SEL_BIT]        = bank_q.rev10;
    rv[OVF_BIT]            = bank_q.ovf;
    rv[UNF_BIT]            = bank_q.unf;
    rv[EBUF_MSB:EBUF_LSB]  = bank_q.ebuf_size;

    // local dibit rate for the read side
    bank_d.div_cnt = tick ? 8'h00 : bank_q.div_cnt + 8'h01;

    // strap caught after reset release, once synchronised
    if (bank_q.strap_cnt != 2'(STRAP_SETTLE)) begin
      bank_d.strap_cnt = bank_q.strap_cnt + 2'h1;
      bank_d.ref_sel   = strap_s;
    end

    // data path
    if (!rmii_act || bypass) begin
      eb_clr       = 1'b1;
      bank_d.state = EB_IDLE;
      bank_d.tog   = 1'b0;
      if (link_rise) begin
        bank_d.crs_dv = dv_s;
        bank_d.rxd    = rxd_s;
      end
    end else begin
      bank_d.rxd = eb_rdata;
      if (link_rise && dv_s && bank_q.state != EB_IDLE) begin
        eb_wr = 1'b1;
        if (eb_fill >= lim || eb_fill == FW'(EB_DEPTH)) begin
          ovf_ev = 1'b1;
        end
      end
      case (bank_q.state)
        EB_IDLE: begin
          bank_d.crs_dv = 1'b0;
          if (link_rise && dv_s) begin
            eb_wr         = 1'b1;
            bank_d.crs_dv = 1'b1;
            bank_d.state  = EB_FILL;
          end
        end
        EB_FILL: begin
          // hold reads until the tolerance margin is banked
          if (eb_fill >= tol || !dv_s) begin
            bank_d.state = EB_RUN;
          end
        end
        EB_RUN: begin
          if (tick) begin
            if (eb_fill != '0) begin
              eb_rd = 1'b1;
            end else if (dv_s) begin
              unf_ev = 1'b1;
            end
          end
          if (!dv_s) begin
            bank_d.tog   = 1'b0;
            bank_d.state = EB_TAIL;
          end
        end
        default: begin
          if (tick) begin
            if (eb_fill == '0) begin
              bank_d.crs_dv = 1'b0;
              bank_d.state  = EB_IDLE;
            end else begin
              eb_rd         = 1'b1;
              bank_d.tog    = ~bank_q.tog;
              bank_d.crs_dv = bank_q.rev10 | bank_q.tog;
            end
          end
        end
      endcase
    end

    // register access; clears first so that events below win
    bank_d.rdata = '0;
    if (RD_EN) begin
      if (hit[0]) begin
        bank_d.rdata = rv;
        bank_d.ovf   = 1'b0;
        bank_d.unf   = 1'b0;
      end else if (hit[1]) begin
        bank_d.rdata = {14'h0000, bank_q.irq_stat};
      end else if (hit[2]) begin
        bank_d.rdata = {14'h0000, bank_q.irq_mask};
      end
    end
    if (WR_EN) begin
      if (hit[0]) begin
        bank_d.tx_shift  = WDATA[TX_SHIFT_BIT];
        bank_d.ref_sel   = WDATA[REF_SEL_BIT];
        bank_d.fifo_norm = WDATA[FIFO_NORM_BIT];
        bank_d.rmii_mode = WDATA[RMII_MODE_BIT];
        bank_d.rev10     = WDATA[REV_SEL_BIT];
        bank_d.ebuf_size = WDATA[EBUF_MSB:EBUF_LSB];
      end else if (hit[1]) begin
        bank_d.irq_stat = bank_q.irq_stat & ~WDATA[1:0];
      end else if (hit[2]) begin
        bank_d.irq_mask = WDATA[1:0];
      end
    end
    if (ovf_ev) begin
      bank_d.ovf                   = 1'b1;
      bank_d.irq_stat[IRQ_OVF_BIT] = 1'b1;
    end
    if (unf_ev) begin
      bank_d.unf                   = 1'b1;
      bank_d.irq_stat[IRQ_UNF_BIT] = 1'b1;
    end
    bank_d.irq = |(bank_d.irq_stat & bank_d.irq_mask);

    bank_d.rx_clk_out = bypass & lclk_s;
    bank_d.tx_shift_o = bank_d.tx_shift;
    bank_d.ref_sel_o  = bank_d.ref_sel;
    bank_d.rmii_act_o = rmii_act;
    bank_d.bypass_o   = bypass;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bank_q           <= '0;
      bank_q.state     <= EB_IDLE;
      bank_q.tx_shift  <= TX_SHIFT_RST;
      bank_q.fifo_norm <= FIFO_NORM_RST;
      bank_q.rmii_mode <= RMII_MODE_RST;
      bank_q.rev10     <= REV_SEL_RST;
      bank_q.ebuf_size <= EBUF_RST;
      bank_q.irq_mask  <= IRQ_MASK_RST;
    end else begin
      bank_q <= bank_d;
    end
  end

  assign RDATA            = bank_q.rdata;
  assign IRQ              = bank_q.irq;
  assign CRS_DV           = bank_q.crs_dv;
  assign RXD              = bank_q.rxd;
  assign RX_CLK_OUT       = bank_q.rx_clk_out;
  assign TX_CLK_SHIFT_EN  = bank_q.tx_shift_o;
  assign REF_CLK_50M_SEL  = bank_q.ref_sel_o;
  assign RMII_MODE_ACT    = bank_q.rmii_act_o;
  assign RX_FIFO_BYPASSED = bank_q.bypass_o;
endmodule // rmii_config_status_bank

/* rtl/rx_elastic_buffer.sv */
`timescale 1ns/1ps
module rx_elastic_buffer #(
  parameter int DEPTH = 16,
  parameter int W     = 2,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         rd,
  output logic      [W-1:0] rdata,
  output logic      [AW:0]  fill
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            rdata;
  } eb_s;

  eb_s eb_q;
  eb_s eb_d;

  always_comb begin
    logic do_wr;
    logic do_rd;
    do_wr = wr & (eb_q.cnt != (AW+1)'(DEPTH));
    do_rd = rd & (eb_q.cnt != '0);
    eb_d  = eb_q;
    if (clr) begin
      eb_d.wp  = '0;
      eb_d.rp  = '0;
      eb_d.cnt = '0;
    end else begin
      if (do_wr) begin
        eb_d.mem[eb_q.wp] = wdata;
        eb_d.wp           = eb_q.wp + 1'b1;
      end
      if (do_rd) begin
        eb_d.rdata = eb_q.mem[eb_q.rp];
        eb_d.rp    = eb_q.rp + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   eb_d.cnt = eb_q.cnt + 1'b1;
        2'b01:   eb_d.cnt = eb_q.cnt - 1'b1;
        default: eb_d.cnt = eb_q.cnt;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eb_q <= '0;
    end else begin
      eb_q <= eb_d;
    end
  end

  assign rdata = eb_q.rdata;
  assign fill  = eb_q.cnt;
endmodule // rx_elastic_buffer

/* tb/link_src.sv */
`timescale 1ns/1ps
module link_src (
  output logic       lclk,
  output logic       dv,
  output logic [1:0] rxd
);
  initial begin
    lclk = 1'b0;
    dv   = 1'b0;
    rxd  = 2'h0;
  end
  // clock only runs inside a frame; two idle dibits close it
  task automatic send(input int n, input int half);
    for (int i = 0; i < n + 2; i++) begin
      dv  = (i < n);
      rxd = (i < n) ? 2'(i + 1) : ~rxd;
      #half lclk = 1'b1;
      #half lclk = 1'b0;
    end
  endtask
endmodule // link_src

/* tb/rmii_bank_chk.sv */
`timescale 1ns/1ps
module rmii_bank_chk
  import rmii_cfg_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              IRQ,
  input wire logic              RX_DV_IN,
  input wire logic              REF_CLOCK_FREQ_STRAP,
  input wire logic              RGMII_EN,
  input wire logic              CRS_DV,
  input wire logic              RX_CLK_OUT,
  input wire logic              TX_CLK_SHIFT_EN,
  input wire logic              REF_CLK_50M_SEL,
  input wire logic              RMII_MODE_ACT,
  input wire logic              RX_FIFO_BYPASSED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_shift_write: assert property (
    WR_EN && ADDR == CTRL_STATUS_OFF |=> TX_CLK_SHIFT_EN == $past(WDATA[TX_SHIFT_BIT]))
    else $error("shift enable not written");
  a_strap_load: assert property (
    $rose(RST_N) |-> ##5 REF_CLK_50M_SEL == REF_CLOCK_FREQ_STRAP)
    else $error("clock select not loaded from strap");
  a_bypass_rmii: assert property (
    RX_FIFO_BYPASSED |-> RMII_MODE_ACT)
    else $error("bypass outside rmii mode");
  a_bypass_write: assert property (
    WR_EN && ADDR == CTRL_STATUS_OFF && !WDATA[FIFO_NORM_BIT] && WDATA[RMII_MODE_BIT]
      && !RGMII_EN && !$past(RGMII_EN) && !$past(RGMII_EN, 2) |=> ##1 RX_FIFO_BYPASSED)
    else $error("bypass not entered after write");
  a_clk_out_gate: assert property (
    !RX_FIFO_BYPASSED && !$past(RX_FIFO_BYPASSED) |-> !RX_CLK_OUT)
    else $error("clock out without bypass");
  a_rgmii_wins: assert property (
    RGMII_EN [*4] |=> !RMII_MODE_ACT)
    else $error("rmii active under rgmii enable");
  a_ctrl_read: assert property (
    $past(RD_EN && ADDR == CTRL_STATUS_OFF)
      |-> RDATA[TX_SHIFT_BIT] == TX_CLK_SHIFT_EN && RDATA[15:9] == 7'h0)
    else $error("control read mismatch");
  a_crs_drop: assert property (
    $fell(RX_DV_IN) |-> ##[1:400] !CRS_DV)
    else $error("carrier valid stuck after frame");
  a_irq_masked: assert property (
    WR_EN && ADDR == IRQ_MASK_OFF && WDATA[1:0] == 2'h0 |=> ##1 !IRQ)
    else $error("interrupt while masked");
endmodule // rmii_bank_chk

bind rmii_config_status_bank rmii_bank_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .IRQ(IRQ), .RX_DV_IN(RX_DV_IN),
  .REF_CLOCK_FREQ_STRAP(REF_CLOCK_FREQ_STRAP), .RGMII_EN(RGMII_EN),
  .CRS_DV(CRS_DV), .RX_CLK_OUT(RX_CLK_OUT), .TX_CLK_SHIFT_EN(TX_CLK_SHIFT_EN),
  .REF_CLK_50M_SEL(REF_CLK_50M_SEL), .RMII_MODE_ACT(RMII_MODE_ACT),
  .RX_FIFO_BYPASSED(RX_FIFO_BYPASSED)
);

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import rmii_cfg_pkg::*;
  logic        clk, rst_n, wr_en, rd_en, irq, strap, rgmii_en;
  logic        lclk, dv, crs_dv, rclk_out, tx_sh, ref50, rmii_act, byp;
  logic        crs_q, ro_q;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [1:0]  rxd_in, rxd;
  int          err_total, checked, cyc, crs_rise, clk_rise, base;
  logic [15:0] ctl[3]  = '{16'h0061, 16'h0071, 16'h0071};
  int          half[3] = '{100, 100, 240};
  logic [15:0] flg[3]  = '{16'h0008, 16'h0008, 16'h0004};
  logic [15:0] irv[3]  = '{16'h0001, 16'h0001, 16'h0002};
  logic [15:0] many[3] = '{16'h0001, 16'h0000, 16'h0000};

  rmii_config_status_bank i_dut (
    .SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
    .RD_EN(rd_en), .RDATA(rdata), .IRQ(irq), .RX_LINK_CLK(lclk), .RX_DV_IN(dv),
    .RXD_IN(rxd_in), .REF_CLOCK_FREQ_STRAP(strap), .RGMII_EN(rgmii_en),
    .CRS_DV(crs_dv), .RXD(rxd), .RX_CLK_OUT(rclk_out), .TX_CLK_SHIFT_EN(tx_sh),
    .REF_CLK_50M_SEL(ref50), .RMII_MODE_ACT(rmii_act), .RX_FIFO_BYPASSED(byp)
  );
  link_src i_src (.lclk(lclk), .dv(dv), .rxd(rxd_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc   <= cyc + 1;
    crs_q <= crs_dv;
    ro_q  <= rclk_out;
    if (crs_dv === 1'b1 && crs_q === 1'b0) crs_rise <= crs_rise + 1;
    if (rclk_out === 1'b1 && ro_q === 1'b0) clk_rise <= clk_rise + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic outs(input logic [15:0] e);
    chk({12'h0, tx_sh, ref50, rmii_act, byp}, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata & m, e);
  endtask

  initial begin
    {err_total, checked, cyc, crs_rise, clk_rise} = '0;
    {rst_n, wr_en, rd_en, rgmii_en} = 4'h0;
    addr  = 8'h0;
    wdata = 16'h0;
    strap = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(CTRL_STATUS_OFF, 16'hffff, 16'h00c1);
    rd(8'h18, 16'hffff, 16'h0000);
    wr(8'h18, 16'hffff);
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_STATUS_OFF, i ? 16'hffff : 16'h0000);
      rd(CTRL_STATUS_OFF, 16'hffff, i ? 16'h01f3 : 16'h0000);
      outs(i ? 16'h000e : 16'h0000);
    end
    @(posedge clk);
    rgmii_en <= 1'b1;
    wr(CTRL_STATUS_OFF, 16'h0061);
    repeat (5) @(posedge clk);
    #1 outs(16'h0000);
    @(posedge clk);
    rgmii_en <= 1'b0;
    repeat (5) @(posedge clk);
    #1 outs(16'h0002);
    wr(CTRL_STATUS_OFF, 16'h0021);
    repeat (5) @(posedge clk);
    #1 outs(16'h0003);
    base = clk_rise;
    i_src.send(6, 160);
    repeat (10) @(posedge clk);
    #1 chk(16'(clk_rise - base), 16'h0008);
    chk({14'h0, rxd}, 16'h0002);
    for (int k = 0; k < 3; k++) begin
      wr(CTRL_STATUS_OFF, ctl[k]);
      base = crs_rise;
      i_src.send(21, half[k]);
      repeat (300) @(posedge clk);
      #1 chk(16'(crs_rise - base > 1), many[k]);
      chk({14'h0, rxd}, 16'h0001);
      rd(CTRL_STATUS_OFF, 16'h000c, flg[k]);
      rd(CTRL_STATUS_OFF, 16'h000c, 16'h0000);
      rd(IRQ_STATUS_OFF, 16'hffff, irv[k]);
      chk({15'h0, irq}, 16'h0000);
      wr(IRQ_MASK_OFF, 16'h0003);
      rd(IRQ_MASK_OFF, 16'hffff, 16'h0003);
      chk({15'h0, irq}, 16'h0001);
      wr(IRQ_STATUS_OFF, 16'h0003);
      rd(IRQ_STATUS_OFF, 16'hffff, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr(IRQ_MASK_OFF, 16'h0000);
    end
    wr(CTRL_STATUS_OFF, 16'h0041);
    base = clk_rise;
    i_src.send(3, 160);
    repeat (10) @(posedge clk);
    #1 chk({14'h0, rxd}, 16'h0003);
    chk(16'(clk_rise - base), 16'h0000);
    outs(16'h0000);
    end_of_test();
  end
endmodule // tb
